/* css_defs.vh */
// Purpose: constants for the clock-synchronous serial transfer engine
// Assumes: 10 MHz system clock, active-low synchronous reset
// Notes: definitions only
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH
`define CSS_FRAME_BITS 4'h8
`define CSS_CNT_W 4
`define CSS_MODE_MASTER 2'h0
`define CSS_MODE_SLAVE 2'h1
`define CSS_SRC_DIV16 2'h0
`define CSS_SRC_DIV8 2'h1
`define CSS_SRC_DIV4 2'h2
`define CSS_SRC_TIMER 2'h3
`define CSS_SRC_RESET 2'h0
`define CSS_SCLK_DIV 5'h10
`define CSS_SCLK_HALF 5'h08
`endif

/* css_sync2.v */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input asynchronous to i_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module css_sync2 (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_d,
    input wire i_init,
    output reg o_q
);
    reg meta_r;
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            // preload the pin's idle level so no false edge follows reset
            meta_r <= i_init;
            o_q <= i_init;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* css_src_div.v */
// Purpose: shift-clock source prescaler and master-mode divide by sixteen
// Assumes: fast oscillator divided copies arrive as i_clk pulses
// Notes: outputs one-cycle pulses for synchronous clock fall and rise
`timescale 1ns/1ps
`default_nettype none
`include "css_defs.vh"
module css_src_div (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_run,
    input wire [1:0] i_src_sel,
    input wire i_timer_uflow,
    output wire o_fall,
    output wire o_rise,
    output reg o_sclk
);
    reg [3:0] pre_r;
    reg tmr_half_r;
    reg [4:0] div_r;
    reg src_tick;
    always @* begin
        case (i_src_sel)
            `CSS_SRC_DIV16: src_tick = (pre_r == 4'hf);
            `CSS_SRC_DIV8: src_tick = (pre_r[2:0] == 3'h7);
            `CSS_SRC_DIV4: src_tick = (pre_r[1:0] == 2'h3);
            `CSS_SRC_TIMER: src_tick = i_timer_uflow & tmr_half_r; // [R24]
            default: src_tick = 1'b0;
        endcase
    end
    // [R23] source selection; [R2] then a further divide by sixteen
    assign o_fall = i_run && src_tick && (div_r == 5'h00);
    assign o_rise = i_run && src_tick && (div_r == `CSS_SCLK_HALF);
    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            pre_r <= 4'h0;
            tmr_half_r <= 1'b0;
            div_r <= 5'h00;
            o_sclk <= 1'b1;
        end else begin
            pre_r <= pre_r + 4'h1;
            if (i_timer_uflow) begin
                tmr_half_r <= ~tmr_half_r;
            end
            if (!i_run) begin
                div_r <= 5'h00;
                o_sclk <= 1'b1;
            end else if (src_tick) begin
                div_r <= (div_r == `CSS_SCLK_DIV - 5'h01) ? 5'h00 : div_r + 5'h01;
                if (div_r == 5'h00) begin
                    o_sclk <= 1'b0;
                end else if (div_r == `CSS_SCLK_HALF) begin
                    o_sclk <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* css_engine.v */
// Purpose: clock-synchronous 8-bit half-duplex serial transfer engine
// Assumes: control bits are plain ports; pins synchronised to i_clk
// Notes: asynchronous modes and parity are not built here
// Behaviour
// [R1] each transfer moves one 8-bit word, one bit per shift clock
// [R2] master divides the selected source by sixteen and drives shift clock out
// [R3] slave uses the external shift clock from the master
// [R4] half duplex: never transmit and receive together
// [R5] frame fixed at eight bits, bit 0 first both ways
// [R6] mode 00 is master, mode 01 is slave
// [R7] clock source selection only matters in master mode
// [R8] no parity in synchronous mode whatever parity enable holds
// [R9] pins are port pins after reset until serial enable is set
// [R10] software keeps both enables cleared until a transfer begins
// [R11] transmit trigger starts master clock, or slave waits for clock
// [R12] transmit shifts one bit out per falling shift clock edge
// [R13] data out holds the last bit until next transmission
// [R14] transmit completion sets the transmit done flag
// [R15] software loads data and triggers once per byte
// [R16] master software checks slave readiness before triggering
// [R17] receive trigger starts master clock, or slave waits for clock
// [R18] receive samples data in on each rising shift clock edge
// [R19] eighth rise copies word to buffer and sets receive done flag
// [R20] slave ready pin low when ready, high when busy
// [R21] ready falls on trigger write, rises at first falling clock edge
// [R22] in master mode the ready pin stays a port pin
// [R23] source field 11 timer, 10 div4, 01 div8, 00 div16 default
// [R24] timer source is timer underflow halved
// [R25] trigger bits read back as busy status
// [R26] software reads each received byte before next reception
// [R27] clearing an enable aborts the transfer and resets the counter
// [R28] transfer ends itself after exactly eight shift clocks
`timescale 1ns/1ps
`default_nettype none
`include "css_defs.vh"
module css_engine (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_mode_select_lo,
    input wire i_mode_select_hi,
    input wire i_clock_source_sel_lo,
    input wire i_clock_source_sel_hi,
    input wire i_parity_enable_bit,
    input wire i_serial_port_enable_bit,
    input wire i_transmit_enable_bit,
    input wire i_receive_enable_bit,
    input wire i_transmit_trigger_wr,
    input wire i_receive_trigger_wr,
    input wire i_flag_clear_tx,
    input wire i_flag_clear_rx,
    input wire [7:0] i_shared_data_wr,
    input wire i_shared_data_we,
    input wire i_timer_uflow,
    input wire i_sclk_pin,
    input wire i_serial_data_in_pin,
    input wire [3:0] i_port_out,
    input wire [3:0] i_port_oe_b,
    output wire [3:0] o_pin_out,
    output wire [3:0] o_pin_oe_b,
    output wire o_transmit_trigger_bit,
    output wire o_receive_trigger_bit,
    output reg o_transmit_done_flag,
    output reg o_receive_done_flag,
    output reg [7:0] o_rx_buffer
);
    localparam ST_IDLE = 2'h0;
    localparam ST_TX = 2'h1;
    localparam ST_RX = 2'h2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] tx_data_r;
    reg [7:0] shift_r;
    reg [3:0] cnt_r;
    reg serial_data_out_pin_r;
    reg slave_ready_pin_r;
    reg sclk_prev_r;
    wire sclk_s;
    wire sin_s;
    wire is_master;
    wire is_slave;
    wire sync_mode;
    wire m_fall;
    wire m_rise;
    wire m_sclk;
    wire fall_ev;
    wire rise_ev;
    wire busy;
    wire abort;

    function sel_mode;
        input [1:0] mode;
        input [1:0] want;
        begin
            sel_mode = (mode == want);
        end
    endfunction

    assign is_master = sel_mode({i_mode_select_hi, i_mode_select_lo}, `CSS_MODE_MASTER); // [R6]
    assign is_slave = sel_mode({i_mode_select_hi, i_mode_select_lo}, `CSS_MODE_SLAVE); // [R6]
    assign sync_mode = is_master | is_slave;
    // parity enable is deliberately never read here
    wire unused_parity = i_parity_enable_bit; // [R8]

    css_sync2 u_sync_sclk (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_d(i_sclk_pin),
        .i_init(1'b1),
        .o_q(sclk_s)
    );
    css_sync2 u_sync_sin (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_d(i_serial_data_in_pin),
        .i_init(1'b1),
        .o_q(sin_s)
    );

    assign busy = (state_r != ST_IDLE);

    css_src_div u_div (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_run(busy && is_master),
        .i_src_sel({i_clock_source_sel_hi, i_clock_source_sel_lo}), // [R7] [R23]
        .i_timer_uflow(i_timer_uflow),
        .o_fall(m_fall),
        .o_rise(m_rise),
        .o_sclk(m_sclk)
    );

    // slave edges come from the synchronised pin, master edges from the divider
    assign fall_ev = is_master ? m_fall : (is_slave & sclk_prev_r & ~sclk_s); // [R2] [R3]
    assign rise_ev = is_master ? m_rise : (is_slave & ~sclk_prev_r & sclk_s); // [R3]

    assign abort = ((state_r == ST_TX) && !i_transmit_enable_bit) ||
                   ((state_r == ST_RX) && !i_receive_enable_bit) || !sync_mode; // [R27]

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                // one direction at a time; transmit wins a simultaneous request
                if (sync_mode && i_transmit_trigger_wr && i_transmit_enable_bit) begin
                    state_nxt = ST_TX; // [R4] [R11]
                end else if (sync_mode && i_receive_trigger_wr && i_receive_enable_bit) begin
                    state_nxt = ST_RX; // [R4] [R17]
                end
            end
            ST_TX: begin
                if (abort) begin
                    state_nxt = ST_IDLE;
                end else if (rise_ev && cnt_r == `CSS_FRAME_BITS) begin
                    state_nxt = ST_IDLE; // [R28]
                end
            end
            ST_RX: begin
                if (abort) begin
                    state_nxt = ST_IDLE;
                end else if (rise_ev && cnt_r == `CSS_FRAME_BITS - 4'h1) begin
                    state_nxt = ST_IDLE; // [R19] [R28]
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
            tx_data_r <= 8'h00;
            shift_r <= 8'h00;
            cnt_r <= 4'h0;
            serial_data_out_pin_r <= 1'b1;
            slave_ready_pin_r <= 1'b1;
            sclk_prev_r <= 1'b1;
            o_transmit_done_flag <= 1'b0;
            o_receive_done_flag <= 1'b0;
            o_rx_buffer <= 8'h00;
        end else begin
            state_r <= state_nxt;
            sclk_prev_r <= sclk_s;
            if (i_shared_data_we) begin
                tx_data_r <= i_shared_data_wr;
            end
            if (state_r == ST_IDLE && state_nxt != ST_IDLE) begin
                cnt_r <= 4'h0;
                shift_r <= (state_nxt == ST_TX) ? tx_data_r : 8'h00;
                if (is_slave) begin
                    slave_ready_pin_r <= 1'b0; // [R20] [R21]
                end
            end else if (abort) begin
                cnt_r <= 4'h0; // [R27]
                slave_ready_pin_r <= 1'b1;
            end else if (state_r == ST_TX) begin
                if (fall_ev) begin
                    slave_ready_pin_r <= 1'b1; // [R21]
                    serial_data_out_pin_r <= shift_r[0]; // [R5] [R12] [R13]
                    shift_r <= {1'b0, shift_r[7:1]}; // [R12]
                    cnt_r <= cnt_r + 4'h1; // [R1]
                end
                if (rise_ev && cnt_r == `CSS_FRAME_BITS) begin
                    o_transmit_done_flag <= 1'b1; // [R14]
                end
            end else if (state_r == ST_RX) begin
                if (fall_ev) begin
                    slave_ready_pin_r <= 1'b1; // [R21]
                end
                if (rise_ev) begin
                    shift_r <= {sin_s, shift_r[7:1]}; // [R5] [R18]
                    cnt_r <= cnt_r + 4'h1; // [R1]
                    if (cnt_r == `CSS_FRAME_BITS - 4'h1) begin
                        o_rx_buffer <= {sin_s, shift_r[7:1]}; // [R19]
                        o_receive_done_flag <= 1'b1; // [R19]
                    end
                end
            end
            // a completion in the same cycle as a clear keeps the flag set
            if (i_flag_clear_tx && !(state_r == ST_TX && !abort && rise_ev &&
                                     cnt_r == `CSS_FRAME_BITS)) begin
                o_transmit_done_flag <= 1'b0;
            end
            if (i_flag_clear_rx && !(state_r == ST_RX && !abort && rise_ev &&
                                     cnt_r == `CSS_FRAME_BITS - 4'h1)) begin
                o_receive_done_flag <= 1'b0;
            end
        end
    end

    assign o_transmit_trigger_bit = (state_r == ST_TX); // [R25]
    assign o_receive_trigger_bit = (state_r == ST_RX); // [R25]

    // pin order: 0 data in, 1 data out, 2 shift clock, 3 ready; oe low drives
    wire ser_on = i_serial_port_enable_bit & sync_mode; // [R9]
    assign o_pin_out[0] = i_port_out[0];
    assign o_pin_oe_b[0] = ser_on ? 1'b1 : i_port_oe_b[0]; // [R9]
    assign o_pin_out[1] = ser_on ? serial_data_out_pin_r : i_port_out[1]; // [R13]
    assign o_pin_oe_b[1] = ser_on ? 1'b0 : i_port_oe_b[1];
    assign o_pin_out[2] = (ser_on && is_master) ? m_sclk : i_port_out[2]; // [R2]
    assign o_pin_oe_b[2] = ser_on ? ~is_master : i_port_oe_b[2]; // [R3]
    assign o_pin_out[3] = (ser_on && is_slave) ? slave_ready_pin_r : i_port_out[3]; // [R20] [R22]
    assign o_pin_oe_b[3] = (ser_on && is_slave) ? 1'b0 : i_port_oe_b[3]; // [R22]
endmodule
`default_nettype wire

/* css_engine_checker.sv */
// Purpose: port assertions for css_engine
// Assumes: pin order din, dout, sclk, ready
// Notes: data values are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module css_engine_checker (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_mode_select_lo,
    input wire logic i_mode_select_hi,
    input wire logic i_serial_port_enable_bit,
    input wire logic i_transmit_enable_bit,
    input wire logic i_receive_enable_bit,
    input wire logic i_transmit_trigger_wr,
    input wire logic i_receive_trigger_wr,
    input wire logic [3:0] i_port_out,
    input wire logic [3:0] i_port_oe_b,
    input wire logic [3:0] o_pin_out,
    input wire logic [3:0] o_pin_oe_b,
    input wire logic o_transmit_trigger_bit,
    input wire logic o_receive_trigger_bit,
    input wire logic o_transmit_done_flag,
    input wire logic o_receive_done_flag,
    input wire logic [7:0] o_rx_buffer
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire tb = o_transmit_trigger_bit;
    wire rb = o_receive_trigger_bit;
    wire ser = i_serial_port_enable_bit && !i_mode_select_hi;
    wire tgo = i_transmit_trigger_wr && i_transmit_enable_bit && !tb && !rb && !i_mode_select_hi;
    wire rgo = i_receive_trigger_wr && i_receive_enable_bit && !tb && !rb && !i_mode_select_hi
        && !i_transmit_trigger_wr;
    property p_half; !(tb && rb); endproperty
    a_half: assert property (p_half) else $error("both directions busy");
    property p_tgo; tgo |=> tb; endproperty
    a_tgo: assert property (p_tgo) else $error("transmit not started");
    property p_rgo; rgo |=> rb; endproperty
    a_rgo: assert property (p_rgo) else $error("receive not started");
    property p_stop; (!i_transmit_enable_bit |=> !tb) and (!i_receive_enable_bit |=> !rb);
    endproperty
    a_stop: assert property (p_stop) else $error("transfer not aborted");
    property p_tend; $rose(o_transmit_done_flag) |-> $fell(tb); endproperty
    a_tend: assert property (p_tend) else $error("transmit flag without end");
    property p_rend; $changed(o_rx_buffer) |-> o_receive_done_flag && $fell(rb); endproperty
    a_rend: assert property (p_rend) else $error("buffer load without flag");
    property p_port; !i_serial_port_enable_bit |-> {o_pin_out, o_pin_oe_b} == {i_port_out, i_port_oe_b};
    endproperty
    a_port: assert property (p_port) else $error("pins not port");
    property p_mrdy; ser && !i_mode_select_lo |-> {o_pin_out[3], o_pin_oe_b[3]} == {i_port_out[3],
        i_port_oe_b[3]}; endproperty
    a_mrdy: assert property (p_mrdy) else $error("master ready pin not port");
    property p_slave_ready_pin; ser && i_mode_select_lo && (tgo || rgo) |=> !o_pin_out[3] && !o_pin_oe_b[3];
    endproperty
    a_slave_ready_pin: assert property (p_slave_ready_pin) else $error("ready not low");
    property p_hold; ser && !tb && $past(tb) == 1'b0 && $stable(ser) |-> $stable(o_pin_out[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("data out moved while idle");
    c_tx: cover property ($rose(o_transmit_done_flag));
    c_rx: cover property ($rose(o_receive_done_flag));
    c_sl: cover property (ser && i_mode_select_lo && tgo);
endmodule
bind css_engine css_engine_checker u_css_engine_checker (.*);
`default_nettype wire

/* css_peer.sv */
// Purpose: behavioural serial device beyond the pins
// Assumes: shift clock idles high, bit 0 first
// Notes: data line flips after the frame, so no stale bit
`timescale 1ns/1ps
`default_nettype none
module css_peer (
    input wire logic i_sclk,
    input wire logic i_clr,
    input wire logic i_mosi,
    input wire logic [7:0] i_tx,
    output var logic o_miso,
    output var logic [7:0] o_rx,
    output var logic [3:0] o_cnt
);
    initial begin
        o_miso = 1'b1;
        o_rx = 8'h00;
        o_cnt = 4'h0;
    end
    always @(posedge i_clr) o_cnt = 4'h0;
    always @(negedge i_sclk) if (o_cnt < 4'h8) o_miso = i_tx[o_cnt[2:0]];
    always @(posedge i_sclk) begin
        if (o_cnt < 4'h8) o_rx[o_cnt[2:0]] = i_mosi;
        if (o_cnt < 4'h8) o_cnt = o_cnt + 4'h1;
        else o_miso = ~o_miso;
    end
endmodule
`default_nettype wire

/* css_engine_test.sv */
// Purpose: self-checking bench for css_engine
// Assumes: 10 MHz clock, peer on the serial pins
// Notes: slave shift clock made here, 40 clocks a bit
`timescale 1ns/1ps
`default_nettype none
module css_engine_test;
    logic i_clk, i_rst_b, i_mode_select_lo, i_mode_select_hi, i_clock_source_sel_lo;
    logic i_clock_source_sel_hi, i_parity_enable_bit, i_serial_port_enable_bit, sclk_t;
    logic i_transmit_enable_bit, i_receive_enable_bit, i_transmit_trigger_wr, pclr;
    logic i_receive_trigger_wr, i_flag_clear_tx, i_flag_clear_rx, i_shared_data_we;
    logic i_timer_uflow, i_serial_data_in_pin, o_transmit_trigger_bit, o_receive_trigger_bit;
    logic o_transmit_done_flag, o_receive_done_flag;
    logic [7:0] i_shared_data_wr, o_rx_buffer, pdata, prx;
    logic [3:0] i_port_out, i_port_oe_b, o_pin_out, o_pin_oe_b, pcnt;
    logic [1:0] ucnt;
    integer seed, errors, checks, i, rnd;
    wire i_sclk_pin = (o_pin_oe_b[2] === 1'b0) ? o_pin_out[2] : sclk_t;
    wire [3:0] st = {o_transmit_trigger_bit, o_receive_trigger_bit, o_transmit_done_flag,
        o_receive_done_flag};
    css_engine u_css_engine (.*);
    css_peer u_css_peer (.i_sclk(i_sclk_pin), .i_clr(pclr), .i_mosi(o_pin_out[1]),
        .i_tx(pdata), .o_miso(i_serial_data_in_pin), .o_rx(prx), .o_cnt(pcnt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic slv, tx, ab, input logic [1:0] sc, input logic [7:0] d);
        integer n = 0, k = 0, f0 = 0, per = 0;
        logic prev = 1'b1;
        rnd = $random(seed);
        @(posedge i_clk);
        i_mode_select_lo <= slv;
        {i_clock_source_sel_hi, i_clock_source_sel_lo} <= sc;
        i_parity_enable_bit <= rnd[8];
        i_transmit_enable_bit <= tx;
        i_receive_enable_bit <= !tx;
        i_shared_data_wr <= d;
        i_shared_data_we <= tx;
        pdata <= rnd[7:0];
        pclr <= 1'b1;
        @(posedge i_clk);
        i_shared_data_we <= 1'b0;
        pclr <= 1'b0;
        if (!slv) chk(pcnt, 0);
        i_transmit_trigger_wr <= tx;
        i_receive_trigger_wr <= !tx;
        @(posedge i_clk);
        i_transmit_trigger_wr <= 1'b0;
        i_receive_trigger_wr <= 1'b0;
        #1 chk(st[3:2], {tx, !tx});
        chk(o_pin_oe_b, {slv ? 1'b0 : i_port_oe_b[3], slv, 2'b01});
        if (slv) chk({o_pin_out[3], o_pin_oe_b[3]}, 0);
        while ((st[3] | st[2]) && n < 6000) begin
            @(posedge i_clk);
            n = n + 1;
            if (slv && n % 20 == 0 && k < 16) begin
                sclk_t <= ~sclk_t;
                k = k + 1;
            end
            if (slv && n == 30) chk(o_pin_out[3], 1);
            i_transmit_trigger_wr <= n == 50 && !tx;
            i_receive_trigger_wr <= n == 50 && tx;
            if (ab && n == 100) i_transmit_enable_bit <= 1'b0;
            if (ab && n == 100) i_receive_enable_bit <= 1'b0;
            if (prev && !i_sclk_pin && f0 > 0 && per == 0) per = n - f0;
            if (prev && !i_sclk_pin) f0 = n;
            prev = i_sclk_pin;
        end
        #1 chk(st, {2'b00, tx & !ab, !tx & !ab});
        if (!ab && tx) chk({pcnt, prx, o_pin_out[1]}, {4'h8, d, d[7]});
        if (!ab && !tx) chk({pcnt, o_rx_buffer}, {4'h8, pdata});
        if (!ab && !slv) chk(per, sc == 2'h3 ? 96 : 256 >> sc);
        if (!slv) chk(o_pin_out[3], i_port_out[3]);
        @(posedge i_clk);
        i_flag_clear_tx <= 1'b1;
        i_flag_clear_rx <= 1'b1;
        sclk_t <= 1'b1;
        i_transmit_enable_bit <= 1'b0;
        i_receive_enable_bit <= 1'b0;
        @(posedge i_clk);
        i_flag_clear_tx <= 1'b0;
        i_flag_clear_rx <= 1'b0;
        #1 chk(st[1:0], 0);
    endtask
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        ucnt <= (ucnt == 2'h2) ? 2'h0 : ucnt + 2'h1;
        i_timer_uflow <= ucnt == 2'h2;
    end
    initial begin
        #5000000;
        errors = errors + 1;
        end_sim;
    end
    initial begin
        {i_clk, i_rst_b, i_mode_select_lo, i_mode_select_hi, i_clock_source_sel_lo,
            i_clock_source_sel_hi, i_parity_enable_bit, i_serial_port_enable_bit,
            i_transmit_enable_bit, i_receive_enable_bit, i_transmit_trigger_wr, pclr,
            i_receive_trigger_wr, i_flag_clear_tx, i_flag_clear_rx, i_shared_data_we,
            i_timer_uflow, ucnt, i_shared_data_wr, pdata, errors, checks} = '0;
        seed = 84;
        sclk_t = 1'b1;
        rnd = $random(seed);
        i_port_out = rnd[3:0];
        i_port_oe_b = rnd[7:4];
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        #1 chk({st, o_rx_buffer}, 0);
        chk({o_pin_out, o_pin_oe_b}, {i_port_out, i_port_oe_b});
        @(posedge i_clk);
        i_serial_port_enable_bit <= 1'b1;
        xfer(1'b0, 1'b1, 1'b0, 2'h2, 8'h80);
        for (i = 0; i < 8; i = i + 1) begin
            rnd = $random(seed);
            xfer(i[2], i[0], 1'b0, i[1:0], rnd[7:0]);
        end
        xfer(1'b0, 1'b1, 1'b1, 2'h0, 8'h5a);
        xfer(1'b1, 1'b0, 1'b1, 2'h1, 8'h00);
        xfer(1'b1, 1'b1, 1'b0, 2'h0, 8'h01);
        end_sim;
    end
endmodule
`default_nettype wire
